// >>> logic/drs_defs.svh
// offsets, field positions, reset values and codes of the readback/select decoder
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH

`define DRS_FRAME_BITS     5'h18
`define DRS_MODE_SPECIAL   2'h0
`define DRS_CODE_RB_SELECT 6'h05
`define DRS_CODE_AB0_WRITE 6'h06
`define DRS_CODE_AB1_WRITE 6'h07
`define DRS_CODE_AB_BLOCK  6'h0B
`define DRS_CODE_MONITOR   6'h0C
`define DRS_CODE_GPIO      6'h0D

`define DRS_CH_ADDR_FIRST  6'h08
`define DRS_CH_ADDR_LAST   6'h17

`define DRS_GLB_CONTROL    8'h01
`define DRS_GLB_OFS_ZERO   8'h02
`define DRS_GLB_OFS_ONE    8'h03
`define DRS_GLB_AB_LOW     8'h06
`define DRS_GLB_AB_HIGH    8'h07
`define DRS_GLB_GPIO       8'h0B

`define DRS_RB_GLOBAL_BIT  15
`define DRS_MON_EN_BIT     5
`define DRS_MON_PIN_BIT    4
`define DRS_GPIO_DIR_BIT   1
`define DRS_GPIO_VAL_BIT   0

`define DRS_AB_RESET       8'h00
`define DRS_MON_CH_RESET   4'h0
`define DRS_PIN_RESET      4'h2

`endif

// >>> logic/drs_pkg.sv
// types shared by the readback/select decoder
`default_nettype none
package drs_pkg;

  typedef enum logic [3:0] {
    DRS_RB_NONE        = 4'h0,
    DRS_RB_INPUT_A     = 4'h1,
    DRS_RB_INPUT_B     = 4'h2,
    DRS_RB_OFFSET_TRIM = 4'h3,
    DRS_RB_GAIN_TRIM   = 4'h4,
    DRS_RB_CONTROL     = 4'h5,
    DRS_RB_OFS_ZERO    = 4'h6,
    DRS_RB_OFS_ONE     = 4'h7,
    DRS_RB_AB_LOW      = 4'h8,
    DRS_RB_AB_HIGH     = 4'h9,
    DRS_RB_GPIO        = 4'hA,
    DRS_RB_RESERVED    = 4'hB
  } drs_rb_src_t;

  typedef enum logic {
    DRS_FR_IDLE  = 1'b0,
    DRS_FR_SHIFT = 1'b1
  } drs_frame_state_t;

endpackage
`default_nettype wire

// >>> logic/drs_pin_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module drs_pin_sync #(
  parameter int unsigned      WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      // stage1 feeds stage2 only; the filter looks at stages two and three
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage1     <= RESET_VAL[i];
          stage2     <= RESET_VAL[i];
          stage3     <= RESET_VAL[i];
          level_o[i] <= RESET_VAL[i];
        end else begin
          stage1 <= pin_i[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            level_o[i] <= stage3;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> logic/drs_decoder.sv
// serial frame decoder for monitor, pin, readback address and A/B select commands
`timescale 1ns/1ns
`default_nettype none
`include "drs_defs.svh"
module drs_decoder (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 sclk_i,
  input  wire logic                 sync_n_i,
  input  wire logic                 sdi_i,
  output logic                      sdo_o,
  output logic                      sdo_oe_o,
  input  wire logic                 gpio_pin_i,
  output logic                      gpio_pin_o,
  output logic                      gpio_pin_oe_o,
  output logic                      mon_enable_o,
  output logic                      mon_pin_mode_o,
  output logic                      monitor_pin_first_o,
  output logic                      monitor_pin_second_o,
  output logic [3:0]                mon_channel_o,
  output logic [15:0]               calc_sel_b_o,
  output drs_pkg::drs_rb_src_t      rb_src_o,
  output logic [3:0]                rb_channel_o,
  input  wire logic [15:0]          rb_data_i
);

  logic [3:0]                  pin_level;
  logic                        sclk_s;
  logic                        sync_n_s;
  logic                        sdi_s;
  logic                        gpio_level;
  logic                        sclk_q;
  logic                        sync_q;
  logic                        sclk_fall;
  logic                        sclk_rise;
  logic                        frame_start;
  logic                        frame_stop;
  logic                        frame_end;
  drs_pkg::drs_frame_state_t   state;
  logic [4:0]                  bit_cnt;
  logic [23:0]                 rx_word;
  logic [23:0]                 shift_out;
  logic                        rb_pending;
  logic                        is_special;
  logic [5:0]                  code;
  logic [15:0]                 field;
  logic                        cmd_rb;
  drs_pkg::drs_rb_src_t        next_rb_src;
  logic [15:0]                 rb_value;
  logic [15:0]                 ab_sel;
  logic                        mon_pin_sel;

  // readback address decode; low seven bits never take part
  function automatic drs_pkg::drs_rb_src_t rb_decode(input logic [15:0] f);
    drs_pkg::drs_rb_src_t src;
    src = drs_pkg::DRS_RB_RESERVED;
    if (!f[`DRS_RB_GLOBAL_BIT]) begin
      if (f[12:7] >= `DRS_CH_ADDR_FIRST && f[12:7] <= `DRS_CH_ADDR_LAST) begin
        unique case (f[14:13])
          2'h0: src = drs_pkg::DRS_RB_INPUT_A;
          2'h1: src = drs_pkg::DRS_RB_INPUT_B;
          2'h2: src = drs_pkg::DRS_RB_OFFSET_TRIM;
          2'h3: src = drs_pkg::DRS_RB_GAIN_TRIM;
        endcase
      end
    end else begin
      case (f[14:7])
        `DRS_GLB_CONTROL:  src = drs_pkg::DRS_RB_CONTROL;
        `DRS_GLB_OFS_ZERO: src = drs_pkg::DRS_RB_OFS_ZERO;
        `DRS_GLB_OFS_ONE:  src = drs_pkg::DRS_RB_OFS_ONE;
        `DRS_GLB_AB_LOW:   src = drs_pkg::DRS_RB_AB_LOW;
        `DRS_GLB_AB_HIGH:  src = drs_pkg::DRS_RB_AB_HIGH;
        `DRS_GLB_GPIO:     src = drs_pkg::DRS_RB_GPIO;
        default:           src = drs_pkg::DRS_RB_RESERVED;
      endcase
    end
    return src;
  endfunction

  // pins arrive from another clock domain
  drs_pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (`DRS_PIN_RESET)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     ({gpio_pin_i, sdi_i, sync_n_i, sclk_i}),
    .level_o   (pin_level)
  );

  assign sclk_s     = pin_level[0];
  assign sync_n_s   = pin_level[1];
  assign sdi_s      = pin_level[2];
  assign gpio_level = pin_level[3];

  // edge history of the filtered serial clock and frame signal
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      sync_q <= sync_n_s;
    end
  end

  assign sclk_fall   = sclk_q & ~sclk_s;
  assign sclk_rise   = ~sclk_q & sclk_s;
  assign frame_start = sync_q & ~sync_n_s;
  assign frame_stop  = ~sync_q & sync_n_s;
  // short or long frames are dropped whole
  assign frame_end   = frame_stop && state == drs_pkg::DRS_FR_SHIFT && bit_cnt == `DRS_FRAME_BITS;

  // frame state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= drs_pkg::DRS_FR_IDLE;
    end else begin
      unique case (state)
        drs_pkg::DRS_FR_IDLE:  if (frame_start) state <= drs_pkg::DRS_FR_SHIFT;
        drs_pkg::DRS_FR_SHIFT: if (frame_stop) state <= drs_pkg::DRS_FR_IDLE;
      endcase
    end
  end

  // input shifter, data taken on falling serial clock, msb first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt <= 5'h00;
      rx_word <= 24'h000000;
    end else if (frame_start) begin
      bit_cnt <= 5'h00;
    end else if (state == drs_pkg::DRS_FR_SHIFT && sclk_fall) begin
      rx_word <= {rx_word[22:0], sdi_s};
      if (bit_cnt <= `DRS_FRAME_BITS) begin
        bit_cnt <= bit_cnt + 5'h01; // counts one past full to flag overlong frames
      end
    end
  end

  // command fields of the received frame
  assign is_special  = rx_word[23:22] == `DRS_MODE_SPECIAL;
  assign code        = rx_word[21:16];
  assign field       = rx_word[15:0];
  assign cmd_rb      = frame_end && is_special && code == `DRS_CODE_RB_SELECT;
  assign next_rb_src = rb_decode(field);

  // readback request; served by the very next complete frame
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rb_pending   <= 1'b0;
      rb_src_o     <= drs_pkg::DRS_RB_NONE;
      rb_channel_o <= 4'h0;
    end else if (frame_end) begin
      rb_pending <= cmd_rb;
      if (cmd_rb) begin
        rb_src_o     <= next_rb_src;
        rb_channel_o <= 4'(field[12:7] - `DRS_CH_ADDR_FIRST);
      end
    end
  end

  // readback word; reserved codes shift out zero
  always_comb begin
    unique case (rb_src_o)
      drs_pkg::DRS_RB_AB_LOW:   rb_value = {8'h00, ab_sel[7:0]};
      drs_pkg::DRS_RB_AB_HIGH:  rb_value = {8'h00, ab_sel[15:8]};
      drs_pkg::DRS_RB_GPIO:     rb_value = {15'h0000, gpio_level};
      drs_pkg::DRS_RB_NONE:     rb_value = 16'h0000;
      drs_pkg::DRS_RB_RESERVED: rb_value = 16'h0000;
      default:                  rb_value = rb_data_i;
    endcase
  end

  // output shifter, loaded at frame start, moves on rising serial clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_out <= 24'h000000;
    end else if (frame_start) begin
      shift_out <= rb_pending ? {8'h00, rb_value} : 24'h000000;
    end else if (state == drs_pkg::DRS_FR_SHIFT && sclk_rise) begin
      shift_out <= {shift_out[22:0], 1'b0};
    end
  end

  assign sdo_o    = shift_out[23];
  assign sdo_oe_o = state == drs_pkg::DRS_FR_SHIFT && rb_pending;

  // A/B select registers, one bit per channel
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ab_sel <= {`DRS_AB_RESET, `DRS_AB_RESET};
    end else if (frame_end && is_special) begin
      if (code == `DRS_CODE_AB0_WRITE) begin
        ab_sel[7:0] <= field[7:0];
      end else if (code == `DRS_CODE_AB1_WRITE) begin
        ab_sel[15:8] <= field[7:0];
      end else if (code == `DRS_CODE_AB_BLOCK) begin
        ab_sel <= (field[7:0] == 8'h00) ? 16'h0000 : 16'hFFFF;
      end
    end
  end

  assign calc_sel_b_o = ab_sel;

  // monitor selection; channel kept while pin mode is chosen
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mon_enable_o   <= 1'b0;
      mon_pin_mode_o <= 1'b0;
      mon_pin_sel    <= 1'b0;
      mon_channel_o  <= `DRS_MON_CH_RESET;
    end else if (frame_end && is_special && code == `DRS_CODE_MONITOR) begin
      mon_enable_o   <= field[`DRS_MON_EN_BIT];
      mon_pin_mode_o <= field[`DRS_MON_PIN_BIT];
      mon_pin_sel    <= field[0];
      if (!field[`DRS_MON_PIN_BIT]) begin
        mon_channel_o <= field[3:0];
      end
    end
  end

  // pin routing only when monitoring is on in pin mode
  assign monitor_pin_first_o  = mon_enable_o & mon_pin_mode_o & ~mon_pin_sel;
  assign monitor_pin_second_o = mon_enable_o & mon_pin_mode_o & mon_pin_sel;

  // general-purpose pin; only the two lowest field bits matter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpio_pin_oe_o <= 1'b0;
      gpio_pin_o    <= 1'b0;
    end else if (frame_end && is_special && code == `DRS_CODE_GPIO) begin
      gpio_pin_oe_o <= field[`DRS_GPIO_DIR_BIT];
      if (field[`DRS_GPIO_DIR_BIT]) begin
        gpio_pin_o <= field[`DRS_GPIO_VAL_BIT];
      end
    end
  end

  a_ab_low_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_AB0_WRITE
    |=> calc_sel_b_o[7:0] == $past(field[7:0]) && $stable(calc_sel_b_o[15:8]))
    else $error("low select register not written");

  a_ab_block_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_AB_BLOCK
    |=> calc_sel_b_o == (($past(field[7:0]) == 8'h00) ? 16'h0000 : 16'hFFFF))
    else $error("block write gave wrong select bits");

  a_gpio_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_GPIO && field[1]
    |=> gpio_pin_oe_o && gpio_pin_o == $past(field[0]))
    else $error("pin not driven at commanded level");

  a_gpio_input: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_GPIO && !field[1]
    |=> !gpio_pin_oe_o [*2])
    else $error("pin driven while set as input");

  a_mon_pin_route: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_MONITOR && field[5] && field[4]
    |=> monitor_pin_second_o == $past(field[0]) && monitor_pin_first_o != $past(field[0]))
    else $error("wrong monitor pin routed");

  a_mon_chan_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_MONITOR && field[4]
    |=> $stable(mon_channel_o))
    else $error("channel changed in pin mode");

  a_mon_chan_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_end && is_special && code == `DRS_CODE_MONITOR && !field[4]
    |=> mon_channel_o == $past(field[3:0]))
    else $error("monitored channel not taken");

  a_rb_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_rb && rb_decode(field) == drs_pkg::DRS_RB_RESERVED
    |=> $stable(calc_sel_b_o) && $stable(gpio_pin_oe_o) && $stable(mon_channel_o))
    else $error("reserved readback changed state");

  a_rb_gpio_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frame_start && rb_pending && rb_src_o == drs_pkg::DRS_RB_GPIO
    |=> shift_out == {23'h000000, $past(gpio_level)})
    else $error("pin level not loaded for readback");

endmodule
`default_nettype wire

// >>> testbench/drs_host_model.sv
// host side of the serial link: sends frames on sdi, collects readback from sdo
`timescale 1ns/1ns
`default_nettype none
module drs_host_model (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  // link idles with clock low and frame high
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // nbits msb first; sdo taken mid-cycle before each sclk rise to avoid edge races
  task automatic frame(input logic [23:0] word, input int nbits, output logic [23:0] rd);
    logic [23:0] w;
    w = word << (24 - nbits);
    rd = '0;
    @(posedge clk_i) sync_n_o <= 1'b0;
    repeat (7) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      @(negedge clk_i) rd = {rd[22:0], sdo_oe_i ? sdo_i : ~rd[0]}; // released line reads as the previous bit inverted
      @(posedge clk_i);
      sclk_o <= 1'b1;
      sdi_o <= w[23];
      w = w << 1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0; // device takes sdi on this fall
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    sync_n_o <= 1'b1;
    sdi_o <= ~sdi_o; // data line not left at its last value
    repeat (12) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_drs_decoder.sv
// self-checking bench for the readback/select decoder
`timescale 1ns/1ns
`default_nettype none
module test_drs_decoder;
  typedef struct {
    logic [15:0] fld;
    logic [3:0]  src;
    logic [3:0]  ch;
    logic [23:0] dat;
  } drs_row_t;
  logic                 clk = 1'b0;
  logic                 reset_n;
  logic                 sclk, sync_n, sdi, sdo, sdo_oe, gpio_in, gpio_out, gpio_oe;
  logic                 mon_en, mon_pm, mon_f, mon_s, ext_lvl;
  logic [3:0]           mon_ch, rb_ch;
  logic [15:0]          sel_b, rb_data;
  drs_pkg::drs_rb_src_t rb_src;
  logic [23:0]          rd;
  int                   num_errors = 0;
  int                   n_tests = 0;
  // per-channel rows take data from rb_data; select rows return 3C/A5
  drs_row_t rows [14] = '{
    '{16'h0400, 4'h1, 4'h0, 24'h005AC3}, '{16'h2BFF, 4'h2, 4'hF, 24'h005AC3},
    '{16'h4780, 4'h3, 4'h7, 24'h005AC3}, '{16'h6800, 4'h4, 4'h8, 24'h005AC3},
    '{16'h80D5, 4'h5, 4'h0, 24'h005AC3}, '{16'h8100, 4'h6, 4'h0, 24'h005AC3},
    '{16'h8180, 4'h7, 4'h0, 24'h005AC3}, '{16'h8300, 4'h8, 4'h0, 24'h00003C},
    '{16'h83FF, 4'h9, 4'h0, 24'h0000A5}, '{16'h8580, 4'hA, 4'h0, 24'h000001},
    '{16'h8200, 4'hB, 4'h0, 24'h000000}, '{16'h8400, 4'hB, 4'h0, 24'h000000},
    '{16'h8480, 4'hB, 4'h0, 24'h000000}, '{16'h8500, 4'hB, 4'h0, 24'h000000}};

  always #20 clk = ~clk;
  // pin wire: device level while it drives, outside level otherwise
  assign gpio_in = gpio_oe ? gpio_out : ext_lvl;

  drs_host_model drs_host_model_inst (
    .clk_i(clk), .sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));
  drs_decoder drs_decoder_inst (
    .clk_i(clk), .reset_n_i(reset_n), .sclk_i(sclk), .sync_n_i(sync_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .gpio_pin_i(gpio_in), .gpio_pin_o(gpio_out),
    .gpio_pin_oe_o(gpio_oe), .mon_enable_o(mon_en), .mon_pin_mode_o(mon_pm),
    .monitor_pin_first_o(mon_f), .monitor_pin_second_o(mon_s), .mon_channel_o(mon_ch),
    .calc_sel_b_o(sel_b), .rb_src_o(rb_src), .rb_channel_o(rb_ch), .rb_data_i(rb_data));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [23:0] w);
    drs_host_model_inst.frame(w, 24, rd);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    ext_lvl = 1'b1;
    rb_data = 16'h5AC3;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    send(24'h0B00FF);
    check("sel_set", sel_b, 24'hFFFF);
    send(24'h0B0000);
    check("sel_clr", sel_b, 24'h0000);
    send(24'h06FF3C);
    send(24'h0700A5);
    check("sel_regs", sel_b, 24'hA53C);
    // block write code outside the special mode must change nothing
    send(24'h4B0000);
    check("sel_mode", sel_b, 24'hA53C);
    send(24'h0D0003);
    check("pin_hi", {gpio_oe, gpio_out}, 24'h3);
    send(24'h0DFFF2);
    check("pin_lo", {gpio_oe, gpio_out}, 24'h2);
    send(24'h0D0000);
    check("pin_in", gpio_oe, 24'h0);
    // readback table: request frame, then a no-op frame carries the data
    foreach (rows[i]) begin
      send({8'h05, rows[i].fld});
      check("rb_src", {20'h0, rb_src}, {20'h0, rows[i].src});
      if (rows[i].src < 4'h5)
        check("rb_ch", rb_ch, rows[i].ch);
      send(24'h000000);
      check("rb_data", rd, rows[i].dat);
    end
    check("sel_kept", sel_b, 24'hA53C);
    // pin read again with the outside level low, so a constant cannot pass
    ext_lvl <= 1'b0;
    send(24'h058580);
    send(24'h000000);
    check("rb_pin_lo", rd, 24'h000000);
    // monitor routing, pin and channel modes
    send(24'h0C003D);
    check("mon_p1", {mon_en, mon_pm, mon_f, mon_s}, 24'hD);
    send(24'h0C0032);
    check("mon_p0", {mon_en, mon_pm, mon_f, mon_s}, 24'hE);
    send(24'h0C002F);
    check("mon_c15", {mon_en, mon_pm, mon_f, mon_s, mon_ch}, 24'h8F);
    send(24'h0C0020);
    check("mon_c0", {mon_en, mon_pm, mon_f, mon_s, mon_ch}, 24'h80);
    // a 23-bit frame must be ignored whole
    drs_host_model_inst.frame(24'h0C003D, 23, rd);
    check("short", {mon_en, mon_pm, mon_f, mon_s, mon_ch}, 24'h80);
    send(24'h0C0010);
    check("mon_off", {mon_en, mon_pm, mon_f, mon_s}, 24'h4);
    send(24'h0D0003);
    // second reset in mid-run returns every output to zero
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("rst", {gpio_oe, gpio_out, mon_en, mon_pm, mon_f, mon_s, sdo_oe, sel_b}, 24'h0);
    check("rst_rb", {rb_src, mon_ch, rb_ch}, 24'h0);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
